// ===== core/opdec_pkg.sv
// shared constants and types for the coprocessor opcode decoder
package opdec_pkg;
    localparam logic [4:0] ESC_PREFIX     = 5'h1b;  // 11011 in the top five bits
    localparam logic [1:0] QS_NOP         = 2'h0;
    localparam logic [1:0] QS_FIRST       = 2'h1;
    localparam logic [1:0] QS_EMPTY       = 2'h2;
    localparam logic [1:0] QS_NEXT        = 2'h3;
    localparam logic [1:0] MOD_NO_DISP    = 2'h0;
    localparam logic [1:0] MOD_DISP8      = 2'h1;
    localparam logic [1:0] MOD_DISP16     = 2'h2;
    localparam logic [1:0] MOD_STACK      = 2'h3;
    localparam logic [2:0] RM_DIRECT      = 3'h6;
    localparam int         RESET_MIN_CYC  = 4;
    localparam logic [2:0] RESET_CNT_MAX  = 3'(RESET_MIN_CYC);
    localparam logic [1:0] SYNC_RST_VAL   = 2'h3;

    typedef enum logic [1:0] {
        FMT_REAL32  = 2'h0,
        FMT_INT32   = 2'h1,
        FMT_REAL64  = 2'h2,
        FMT_INT16   = 2'h3
    } operand_fmt_t;

    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_LOAD     = 4'h1,
        OP_STORE    = 4'h2,
        OP_STPOP    = 4'h3,
        OP_XCHG     = 4'h4,
        OP_CMP      = 4'h5,
        OP_CMPPOP   = 4'h6,
        OP_CMPPP    = 4'h7,
        OP_OTHER    = 4'h8
    } op_kind_t;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'b00001,
        ST_MODRM    = 5'b00010,
        ST_DLO      = 5'b00100,
        ST_DHI      = 5'b01000,
        ST_XFER     = 5'b10000
    } dec_state_t;
endpackage : opdec_pkg

// ===== core/coprocessor_opcode_decoder.sv
// decoder of escape-prefixed coprocessor instructions taken from the host queue
// Function
// - reset synchronised, abandons activity immediately
// - format field selects operand type
// - mode field governs displacement bytes
// - rm field selects address base register
// - mode 00, rm 110 is direct address
// - recognise load forms
// - recognise store and store-pop forms
// - 00111001 plus index is exchange
// - recognise memory and register compares
// - 11011011001 is compare with double pop
module coprocessor_opcode_decoder
    import opdec_pkg::*;
(
    input  wire logic        clk,            // system clock
    input  wire logic        arst_n,         // power-on reset, active low
    input  wire logic        reset_in,       // device reset pin, active high
    input  wire logic        ready,          // memory ready, active high
    input  wire logic [1:0]  queue_status_lines, // host queue status
    input  wire logic [7:0]  queue_byte,     // byte leaving the host queue
    input  wire logic [15:0] reg_bx,         // host base registers
    input  wire logic [15:0] reg_bp,         // host base pointer
    input  wire logic [15:0] reg_si,         // host source index
    input  wire logic [15:0] reg_di,         // host destination index
    output logic             dec_valid,      // one-cycle pulse: decode done
    output op_kind_t         op_kind,        // decoded operation
    output operand_fmt_t     operand_format_field, // memory operand type
    output logic             mem_operand,    // operand lives in memory
    output logic [2:0]       stack_index,    // indexed stack register number
    output logic [15:0]      effective_address, // memory operand address
    output logic             xfer_active,    // memory transfer in progress
    output logic             reset_active    // synchronised reset seen
);
    typedef struct packed {
        logic [1:0]   rst_sync;
        logic [2:0]   rst_cnt;
        dec_state_t   st;
        logic [2:0]   op_hi;
        logic [1:0]   mode;
        logic [5:0]   op_lo;
        logic [7:0]   dlo;
        logic         valid;
        op_kind_t     kind;
        operand_fmt_t fmt;
        logic         mem;
        logic [2:0]   sidx;
        logic [15:0]  ea;
        logic         xfer;
    } state_t;

    state_t s_q, s_d;

    logic       rst_now;
    logic [2:0] rm;
    logic [2:0] reg_f;
    logic [15:0] disp;
    logic [15:0] base;
    op_kind_t   kind_c;

    // two flops; only the second one is looked at
    assign rst_now = s_q.rst_sync[1];
    assign rm      = s_q.op_lo[2:0];
    assign reg_f   = s_q.op_lo[5:3];

    // classify from op_hi, mode, reg field and rm
    always_comb begin
        kind_c = OP_OTHER;
        if (s_q.mode != MOD_STACK) begin
            if (s_q.op_hi[0] && reg_f == 3'h0)
                kind_c = OP_LOAD;
            else if (s_q.op_hi == 3'h7 && (reg_f == 3'h5 || reg_f == 3'h4))
                kind_c = OP_LOAD;
            else if (s_q.op_hi == 3'h3 && reg_f == 3'h5)
                kind_c = OP_LOAD;
            else if (s_q.op_hi[0] && reg_f == 3'h2)
                kind_c = OP_STORE;
            else if (s_q.op_hi[0] && reg_f == 3'h3)
                kind_c = OP_STPOP;
            else if ((s_q.op_hi == 3'h7 || s_q.op_hi == 3'h3) && reg_f == 3'h7)
                kind_c = OP_STPOP;
            else if (s_q.op_hi == 3'h7 && reg_f == 3'h6)
                kind_c = OP_STPOP;
            else if (!s_q.op_hi[0] && reg_f == 3'h2)
                kind_c = OP_CMP;
            else if (!s_q.op_hi[0] && reg_f == 3'h3)
                kind_c = OP_CMPPOP;
        end else begin
            case ({s_q.op_hi, s_q.mode, reg_f})
                8'h38: kind_c = OP_LOAD;
                8'h39: kind_c = OP_XCHG;
                8'hba: kind_c = OP_STORE;
                8'hbb: kind_c = OP_STPOP;
                8'h1a: kind_c = OP_CMP;
                8'h1b: kind_c = OP_CMPPOP;
                8'hdb: kind_c = (rm == 3'h1) ? OP_CMPPP : OP_OTHER;
                default: kind_c = OP_OTHER;
            endcase
        end
    end

    // displacement per mode; mode 00 rm 110 keeps the 16-bit word alone
    always_comb begin
        case (s_q.mode)
            MOD_DISP8: disp = {{8{queue_byte[7]}}, queue_byte};
            default:   disp = {queue_byte, s_q.dlo};
        endcase
        case (rm)
            3'h0:    base = 16'(reg_bx + reg_si);
            3'h1:    base = 16'(reg_bx + reg_di);
            3'h2:    base = 16'(reg_bp + reg_si);
            3'h3:    base = 16'(reg_bp + reg_di);
            3'h4:    base = reg_si;
            3'h5:    base = reg_di;
            3'h6:    base = reg_bp;
            default: base = reg_bx;
        endcase
    end

    always_comb begin
        s_d          = s_q;
        s_d.valid    = 1'b0;
        s_d.rst_sync = {s_q.rst_sync[0], reset_in};
        if (rst_now && s_q.rst_cnt != RESET_CNT_MAX)
            s_d.rst_cnt = 3'(s_q.rst_cnt + 3'h1);
        else if (!rst_now)
            s_d.rst_cnt = 3'h0;
        if (rst_now) begin
            // any decode or transfer dropped at once
            s_d.st   = ST_IDLE;
            s_d.xfer = 1'b0;
        end else begin
            case (s_q.st)
                ST_IDLE: begin
                    if (queue_status_lines == QS_FIRST &&
                        queue_byte[7:3] == ESC_PREFIX) begin
                        s_d.op_hi = queue_byte[2:0];
                        s_d.st    = ST_MODRM;
                    end
                end
                ST_MODRM: begin
                    if (queue_status_lines == QS_EMPTY)
                        s_d.st = ST_IDLE;
                    else if (queue_status_lines == QS_NEXT) begin
                        s_d.mode  = queue_byte[7:6];
                        s_d.op_lo = queue_byte[5:0];
                        s_d.fmt   = operand_fmt_t'(s_q.op_hi[2:1]);
                        if (queue_byte[7:6] == MOD_STACK ||
                            (queue_byte[7:6] == MOD_NO_DISP &&
                             queue_byte[2:0] != RM_DIRECT))
                            s_d.st = ST_XFER;
                        else
                            s_d.st = ST_DLO;
                    end
                end
                ST_DLO: begin
                    if (queue_status_lines == QS_EMPTY)
                        s_d.st = ST_IDLE;
                    else if (queue_status_lines == QS_NEXT) begin
                        s_d.dlo = queue_byte;
                        s_d.st  = (s_q.mode == MOD_DISP8) ? ST_XFER : ST_DHI;
                    end
                end
                ST_DHI: begin
                    if (queue_status_lines == QS_EMPTY)
                        s_d.st = ST_IDLE;
                    else if (queue_status_lines == QS_NEXT)
                        s_d.st = ST_XFER;
                end
                ST_XFER: begin
                    if (!s_q.xfer) begin
                        s_d.kind = kind_c;
                        s_d.mem  = (s_q.mode != MOD_STACK);
                        s_d.sidx = rm;
                        s_d.valid = 1'b1;
                        s_d.xfer  = (s_q.mode != MOD_STACK);
                        if (s_q.mode == MOD_STACK)
                            s_d.st = ST_IDLE;
                    end else if (ready) begin
                        s_d.xfer = 1'b0;
                        s_d.st   = ST_IDLE;
                    end
                end
                default: s_d.st = ST_IDLE;
            endcase
        end
        // address latched as the modrm byte (mode 00, rm not 110) or the last displacement byte arrives
        if (!rst_now && queue_status_lines == QS_NEXT) begin
            if (s_q.st == ST_MODRM && queue_byte[7:6] == MOD_NO_DISP &&
                queue_byte[2:0] != RM_DIRECT)
                s_d.ea = (queue_byte[2:0] == 3'h4) ? reg_si :
                         (queue_byte[2:0] == 3'h5) ? reg_di :
                         (queue_byte[2:0] == 3'h7) ? reg_bx :
                         (queue_byte[2:0] == 3'h0) ? 16'(reg_bx + reg_si) :
                         (queue_byte[2:0] == 3'h1) ? 16'(reg_bx + reg_di) :
                         (queue_byte[2:0] == 3'h2) ? 16'(reg_bp + reg_si) :
                         16'(reg_bp + reg_di);
            else if (s_q.st == ST_DLO && s_q.mode == MOD_DISP8)
                s_d.ea = 16'(base + disp);
            else if (s_q.st == ST_DHI && s_q.mode == MOD_NO_DISP)
                s_d.ea = disp;
            else if (s_q.st == ST_DHI)
                s_d.ea = 16'(base + disp);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q          <= '0;
            s_q.rst_sync <= SYNC_RST_VAL;
            s_q.st       <= ST_IDLE;
            s_q.kind     <= OP_NONE;
            s_q.fmt      <= FMT_REAL32;
        end else begin
            s_q <= s_d;
        end
    end

    assign dec_valid            = s_q.valid;
    assign op_kind              = s_q.kind;
    assign operand_format_field = s_q.fmt;
    assign mem_operand          = s_q.mem;
    assign stack_index          = s_q.sidx;
    assign effective_address    = s_q.ea;
    assign xfer_active          = s_q.xfer;
    assign reset_active         = rst_now;

    a_reset_abandon: assert property (@(posedge clk) disable iff (!arst_n)
        rst_now |=> (s_q.st == ST_IDLE && !s_q.xfer))
        else $error("reset did not abandon activity");
    a_xfer_waits_ready: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.xfer && !ready && !rst_now) |=> s_q.xfer)
        else $error("transfer ended without ready");
    a_mem_starts_xfer: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.valid && s_q.mem) |-> s_q.xfer)
        else $error("memory operand without transfer");
    a_fmt_from_opcode: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.valid |-> s_q.fmt == operand_fmt_t'(s_q.op_hi[2:1]))
        else $error("format field mismatch");
    a_stack_no_mem: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.valid |-> (s_q.mem == (s_q.mode != MOD_STACK)))
        else $error("stack mode flagged as memory");
    // address checks rebuild the sum from the host registers, not from base or disp
    a_disp8_bx_base: assert property (@(posedge clk) disable iff (!arst_n)
        (!rst_now && s_q.st == ST_DLO && s_q.mode == MOD_DISP8 && rm == 3'h7 &&
         queue_status_lines == QS_NEXT)
        |=> s_q.ea == 16'($past(reg_bx) + {{8{$past(queue_byte[7])}}, $past(queue_byte)}))
        else $error("short displacement address wrong");
    a_disp16_bp_di: assert property (@(posedge clk) disable iff (!arst_n)
        (!rst_now && s_q.st == ST_DHI && s_q.mode == MOD_DISP16 && rm == 3'h3 &&
         queue_status_lines == QS_NEXT)
        |=> s_q.ea == 16'($past(reg_bp) + $past(reg_di) + {$past(queue_byte), $past(s_q.dlo)}))
        else $error("long displacement address wrong");
    a_direct_address: assert property (@(posedge clk) disable iff (!arst_n)
        (!rst_now && s_q.st == ST_DHI && s_q.mode == MOD_NO_DISP &&
         queue_status_lines == QS_NEXT) |=> s_q.ea == {$past(queue_byte), $past(s_q.dlo)})
        else $error("direct address wrong");
    a_si_base: assert property (@(posedge clk) disable iff (!arst_n)
        (!rst_now && s_q.st == ST_MODRM && queue_status_lines == QS_NEXT &&
         queue_byte == 8'h04) |=> s_q.ea == $past(reg_si))
        else $error("si base wrong");
    a_xchg_decode: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.valid && s_q.op_hi == 3'h1 && s_q.mode == MOD_STACK && reg_f == 3'h1)
        |-> s_q.kind == OP_XCHG)
        else $error("exchange not decoded");
    a_cmppp_decode: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.valid && s_q.op_hi == 3'h6 && s_q.mode == MOD_STACK && s_q.op_lo == 6'h19)
        |-> s_q.kind == OP_CMPPP)
        else $error("double-pop compare not decoded");
    a_escape_only: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.st == ST_IDLE && !rst_now && queue_byte[7:3] != ESC_PREFIX) |=> s_q.st == ST_IDLE)
        else $error("non-escape byte accepted");
    a_flush_to_idle: assert property (@(posedge clk) disable iff (!arst_n)
        (!rst_now && (s_q.st == ST_MODRM || s_q.st == ST_DLO || s_q.st == ST_DHI) &&
         queue_status_lines == QS_EMPTY) |=> s_q.st == ST_IDLE)
        else $error("queue flush did not drop the instruction");
    a_load_decode: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.valid && s_q.mode != MOD_STACK && s_q.op_hi[0] && reg_f == 3'h0)
        |-> s_q.kind == OP_LOAD)
        else $error("load not decoded");
    a_bcd_load_decode: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.valid && s_q.mode != MOD_STACK && s_q.op_hi == 3'h7 && reg_f == 3'h4)
        |-> s_q.kind == OP_LOAD)
        else $error("decimal load not decoded");
    a_stpop_decode: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.valid && s_q.mode != MOD_STACK && s_q.op_hi == 3'h7 && reg_f == 3'h6)
        |-> s_q.kind == OP_STPOP)
        else $error("decimal store-pop not decoded");
    a_cmp_decode: assert property (@(posedge clk) disable iff (!arst_n)
        (s_q.valid && s_q.mode != MOD_STACK && !s_q.op_hi[0] && reg_f == 3'h2)
        |-> s_q.kind == OP_CMP)
        else $error("memory compare not decoded");

    // rst_cnt feeds only this cover; a short pin pulse is the host's fault, not ours
    c_mem_xfer:  cover property (@(posedge clk) s_q.xfer ##1 !s_q.xfer);
    c_stack_op:  cover property (@(posedge clk) s_q.valid && !s_q.mem);
    c_disp16:    cover property (@(posedge clk) s_q.st == ST_DHI);
    c_rst_abort: cover property (@(posedge clk) s_q.xfer && rst_now);
    c_rst_held:  cover property (@(posedge clk) s_q.rst_cnt == RESET_CNT_MAX);
endmodule : coprocessor_opcode_decoder

// ===== sim/host_mem_model.sv
// host queue driver and memory ready responder facing the opcode decoder
module host_mem_model
    import opdec_pkg::*;
(
    input  wire logic       clk,                // system clock
    input  wire logic       xfer_active,        // transfer pending in the decoder
    output logic [1:0]      queue_status_lines, // host queue status
    output logic [7:0]      queue_byte,         // byte leaving the host queue
    output logic            ready               // memory ready, active high
);
    timeunit 1ns;
    timeprecision 1ps;

    int ready_delay = 0;
    int wait_cnt    = 0;

    initial begin
        queue_status_lines = QS_NOP;
        queue_byte         = 8'h00;
        ready              = 1'b0;
    end

    // memory answers after ready_delay cycles; ready is one cycle wide
    always @(negedge clk) begin
        if (ready) begin
            ready    <= 1'b0;
            wait_cnt <= 0;
        end else if (xfer_active === 1'b1) begin
            if (wait_cnt >= ready_delay)
                ready <= 1'b1;
            else
                wait_cnt <= wait_cnt + 1;
        end else begin
            wait_cnt <= 0;
        end
    end

    // one queue event per cycle, status and byte change together
    task automatic put(input logic [1:0] st, input logic [7:0] b);
        @(negedge clk);
        queue_status_lines = st;
        queue_byte         = b;
    endtask : put

    // no queue activity: byte lines no longer carry the last value
    task automatic idle();
        @(negedge clk);
        queue_status_lines = QS_NOP;
        queue_byte         = ~queue_byte;
    endtask : idle
endmodule : host_mem_model

// ===== sim/coprocessor_opcode_decoder_tb_top.sv
// self-checking bench for the coprocessor opcode decoder
module coprocessor_opcode_decoder_tb_top import opdec_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        op_kind_t     op;
        operand_fmt_t fmt;
        logic         mem;
        logic [2:0]   idx;
        logic [15:0]  ea;
    } exp_t;

    logic clk = 1'b0;
    logic arst_n, reset_in, ready, dec_valid, mem_operand, xfer_active, reset_active;
    logic [1:0]  queue_status_lines;
    logic [7:0]  queue_byte;
    logic [15:0] reg_bx, reg_bp, reg_si, reg_di, effective_address;
    logic [2:0]  stack_index, lo3;
    op_kind_t     op_kind;
    operand_fmt_t operand_format_field;
    exp_t exp_q[$];
    exp_t mon_e;
    int   err_count = 0;
    int   check_count = 0;
    int   seed = 51;
    int   t, n;
    logic [5:0] form_code [11] = '{6'h08, 6'h0a, 6'h0b, 6'h02, 6'h03, 6'h3d, 6'h1d, 6'h3c,
                                   6'h3f, 6'h1f, 6'h3e};
    op_kind_t form_op [11] = '{OP_LOAD, OP_STORE, OP_STPOP, OP_CMP, OP_CMPPOP, OP_LOAD,
                               OP_LOAD, OP_LOAD, OP_STPOP, OP_STPOP, OP_STPOP};

    // high phase about one third of the period
    always #(clk ? 1.333 : 2.667) clk = ~clk;

    coprocessor_opcode_decoder u_dut (
        .clk(clk), .arst_n(arst_n), .reset_in(reset_in), .ready(ready),
        .queue_status_lines(queue_status_lines), .queue_byte(queue_byte),
        .reg_bx(reg_bx), .reg_bp(reg_bp), .reg_si(reg_si), .reg_di(reg_di),
        .dec_valid(dec_valid), .op_kind(op_kind), .operand_format_field(operand_format_field),
        .mem_operand(mem_operand), .stack_index(stack_index),
        .effective_address(effective_address), .xfer_active(xfer_active),
        .reset_active(reset_active)
    );

    host_mem_model u_host (
        .clk(clk), .xfer_active(xfer_active), .queue_status_lines(queue_status_lines),
        .queue_byte(queue_byte), .ready(ready)
    );

    task automatic fail(input string m);
        err_count++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    function automatic logic [15:0] ea_of(input logic [1:0] md, input logic [2:0] rm,
                                          input logic [15:0] d);
        logic [15:0] base;
        case (rm)
            3'h0: base = reg_bx + reg_si;
            3'h1: base = reg_bx + reg_di;
            3'h2: base = reg_bp + reg_si;
            3'h3: base = reg_bp + reg_di;
            3'h4: base = reg_si;
            3'h5: base = reg_di;
            3'h6: base = (md == 2'h0) ? 16'h0000 : reg_bp;
            default: base = reg_bx;
        endcase
        return base + d;
    endfunction : ea_of

    task automatic wait_idle(output int cyc);
        for (cyc = 0; cyc < 64 && (exp_q.size() != 0 || xfer_active !== 1'b0); cyc++)
            @(negedge clk);
        if (cyc == 64) begin
            fail("decoder stuck busy");
            complete_run();
        end
        @(negedge clk);
    endtask : wait_idle

    // one instruction: escape byte, modrm, then displacement bytes by mode
    task automatic issue(input logic [2:0] l3, input logic [2:0] rg, input op_kind_t op,
                         input logic [1:0] md, input logic [2:0] rm, input logic hold);
        logic [15:0] d;
        int          nd;
        @(negedge clk);
        reg_bx = 16'($random(seed));
        reg_bp = 16'($random(seed));
        reg_si = 16'($random(seed));
        reg_di = 16'($random(seed));
        d      = 16'($random(seed));
        nd     = (md == 2'h1) ? 1 : (md == 2'h2 || (md == 2'h0 && rm == RM_DIRECT)) ? 2 : 0;
        if (md == 2'h1) d = {{8{d[7]}}, d[7:0]};
        if (nd == 0) d = 16'h0000;
        exp_q.push_back(exp_t'{op, operand_fmt_t'(l3[2:1]), md != 2'h3, rm, ea_of(md, rm, d)});
        u_host.put(QS_FIRST, {ESC_PREFIX, l3});
        u_host.put(QS_NEXT, {md, rg, rm});
        if (nd > 0) u_host.put(QS_NEXT, d[7:0]);
        if (nd > 1) u_host.put(QS_NEXT, d[15:8]);
        u_host.idle();
        if (hold) wait_idle(n);
    endtask : issue

    // sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge clk) begin
        if (dec_valid === 1'b1) begin
            check_count++;
            if (exp_q.size() == 0) begin
                fail("decode with nothing pending");
            end else begin
                mon_e = exp_q.pop_front();
                check_count += 4;
                if (op_kind !== mon_e.op) fail("operation kind");
                if (operand_format_field !== mon_e.fmt) fail("operand format");
                if (mem_operand !== mon_e.mem || stack_index !== mon_e.idx) fail("operand");
                if (mon_e.mem && effective_address !== mon_e.ea) fail("address");
            end
        end
    end

    initial begin
        arst_n = 1'b0;
        reset_in = 1'b0;
        {reg_bx, reg_bp, reg_si, reg_di} = '0;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        for (int k = 0; k < 48; k++) begin
            t = $unsigned($random(seed)) % 11;
            lo3 = form_code[t][5:3];
            if (t < 5) lo3[2:1] = 2'(k % 4);
            issue(lo3, form_code[t][2:0], form_op[t], 2'((k / 8) % 3), 3'(k % 8), 1'b1);
        end
        $display("test memory forms done");
        issue(3'h1, 3'h0, OP_LOAD, 2'h3, 3'h1, 1'b1);
        issue(3'h1, 3'h1, OP_XCHG, 2'h3, 3'h5, 1'b1);
        issue(3'h0, 3'h2, OP_CMP, 2'h3, 3'h1, 1'b1);
        issue(3'h0, 3'h3, OP_CMPPOP, 2'h3, 3'h7, 1'b1);
        issue(3'h5, 3'h2, OP_STORE, 2'h3, 3'h3, 1'b1);
        issue(3'h5, 3'h3, OP_STPOP, 2'h3, 3'h6, 1'b1);
        issue(3'h6, 3'h3, OP_CMPPP, 2'h3, 3'h1, 1'b1);
        $display("test register forms done");
        u_host.put(QS_FIRST, 8'h90);
        u_host.put(QS_NEXT, 8'hc0);
        u_host.put(QS_FIRST, {ESC_PREFIX, 3'h1});
        u_host.put(QS_EMPTY, 8'h00);
        u_host.put(QS_NEXT, 8'hc1);
        u_host.idle();
        repeat (4) @(negedge clk);
        issue(3'h1, 3'h1, OP_XCHG, 2'h3, 3'h2, 1'b1);
        $display("test ignored and flushed bytes done");
        u_host.ready_delay = 6;
        issue(3'h5, 3'h0, OP_LOAD, 2'h0, 3'h4, 1'b1);
        check_count++;
        if (n < 5) fail("transfer ended before ready");
        u_host.ready_delay = 200;
        issue(3'h3, 3'h0, OP_LOAD, 2'h1, 3'h0, 1'b0);
        repeat (3) @(negedge clk);
        reset_in = 1'b1;  // held well beyond four cycles
        for (n = 0; n < 5 && !(reset_active === 1'b1 && xfer_active === 1'b0); n++)
            @(negedge clk);
        check_count++;
        if (n == 5) fail("reset did not abandon the transfer");
        repeat (4) @(negedge clk);
        reset_in = 1'b0;
        for (n = 0; n < 5 && reset_active !== 1'b0; n++)
            @(negedge clk);
        check_count++;
        if (n == 5) fail("reset stayed active");
        u_host.ready_delay = 0;
        issue(3'h7, 3'h5, OP_LOAD, 2'h2, 3'h7, 1'b1);
        $display("test ready and reset done");
        check_count++;
        if (exp_q.size() != 0) fail("decodes missing");
        complete_run();
    end
endmodule : coprocessor_opcode_decoder_tb_top
